//--- core/timer_core.sv
// 16-bit timer with PWM, capture, compare and gated modes behind a
// classic Wishbone slave. Assumes timer_in is synchronous to core_clk.
//
// Chosen here: register access over Wishbone and the register offsets.
`timescale 1ns/100ps

module timer_core
  import timer_pkg::*;
(
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              nrst,
  // Wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADR_W-1:0]  wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  // Timer pins and event
  input  wire logic              timer_in,
  output logic                   timer_out,
  output logic                   timer_out_en,
  output logic                   timer_event
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Merges the two low byte lanes of a write into a 16-bit register.
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0]  sel);
    merge16 = {sel[1] ? data[15:8] : old[15:8],
               sel[0] ? data[7:0]  : old[7:0]};
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [CTRL_W-1:0] ctrl;
  logic              capture_event_flag;
  logic [15:0]       count;
  logic [15:0]       reload;
  logic [15:0]       pwm;
  logic [6:0]        pre_cnt;
  logic              in_prev;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire        bus_req   = wb_cyc_i & wb_stb_i;
  wire        wr_go     = bus_req & wb_we_i & wb_ack_o;
  wire        wr_ctrl   = wr_go & (wb_adr_i == CTRL_OFS) & wb_sel_i[0];
  wire        wr_count  = wr_go & (wb_adr_i == COUNT_OFS);
  wire        wr_reload = wr_go & (wb_adr_i == RELOAD_OFS);
  wire        wr_pwm    = wr_go & (wb_adr_i == PWM_OFS);
  // Lane 1 carries only the pin enable; the flag bit above it is read only.
  wire [CTRL_W-1:0] ctrl_new = {wb_sel_i[1] ? wb_dat_i[OE_BIT] : ctrl[OE_BIT],
                                wb_dat_i[INIT_BIT:0]};

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  wire        enable              = ctrl[EN_BIT];
  wire [1:0]  mode                = ctrl[MODE_LSB +: 2];
  wire        input_polarity_select = ctrl[POL_BIT];
  wire [2:0]  pre_sel             = ctrl[PRE_LSB +: 3];
  wire [7:0]  pre_pow             = 8'h01 << pre_sel;
  wire [6:0]  pre_lim             = 7'(pre_pow - 8'h01);

  // ----------------------------------------------------------------
  // Count engine
  // ----------------------------------------------------------------
  wire in_active   = (timer_in == input_polarity_select);
  wire prev_active = (in_prev == input_polarity_select);
  wire run         = enable & ((mode != MODE_GATE) | in_active);
  wire tick        = run & (pre_cnt == pre_lim);
  wire at_reload   = (count == reload);
  wire reload_evt  = tick & at_reload;
  wire rise        = timer_in & ~in_prev;
  wire fall        = ~timer_in & in_prev;
  wire cap_edge    = input_polarity_select ? rise : fall;
  wire cap_evt     = enable & (mode == MODE_CAP) & cap_edge;
  wire gate_off    = enable & (mode == MODE_GATE) & prev_active & ~in_active;
  wire any_evt     = cap_evt | gate_off | reload_evt;
  wire pwm_high    = input_polarity_select ? (count <= pwm)
                                           : (count > pwm);
  wire [15:0] next_count = wr_count   ? merge16(count, wb_dat_i, wb_sel_i) :
                           reload_evt ? START_CNT :
                           tick       ? 16'(count + 16'h0001) :
                           count;
  wire [15:0] next_pwm   = cap_evt ? count :
                           wr_pwm  ? merge16(pwm, wb_dat_i, wb_sel_i) :
                           pwm;
  wire [15:0] next_reload = wr_reload ? merge16(reload, wb_dat_i, wb_sel_i) : reload;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pre_cnt <= PRE_RST;
    end else if (!run || tick) begin
      pre_cnt <= PRE_RST;
    end else begin
      pre_cnt <= 7'(pre_cnt + 7'h01);
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      count   <= COUNT_RST;
      reload  <= RELOAD_RST;
      pwm     <= PWM_RST;
      in_prev <= 1'b0;
    end else begin
      count   <= next_count;
      reload  <= next_reload;
      pwm     <= next_pwm;
      in_prev <= timer_in;
    end
  end

  // The flag is set by capture and cleared by a reload in capture mode; set wins.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      capture_event_flag <= 1'b0;
    end else if (cap_evt) begin
      capture_event_flag <= 1'b1;
    end else if (reload_evt && mode == MODE_CAP) begin
      capture_event_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Control register and output pin
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl <= CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl <= ctrl_new;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      timer_out <= 1'b0;
    end else if (wr_ctrl && !ctrl_new[EN_BIT]) begin
      timer_out <= ctrl_new[INIT_BIT];
    end else if (enable && mode == MODE_PWM) begin
      timer_out <= pwm_high;
    end else if (reload_evt) begin
      timer_out <= ~timer_out;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      timer_event  <= 1'b0;
      timer_out_en <= 1'b0;
    end else begin
      timer_event  <= any_evt;
      timer_out_en <= ctrl[OE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Read path and acknowledge
  // ----------------------------------------------------------------
  wire [31:0] rd_ctrl   = {22'h000000, capture_event_flag, ctrl};
  wire [31:0] rd_status = {29'h00000000, capture_event_flag, timer_out, timer_in};
  wire [31:0] rd_word   = (wb_adr_i == CTRL_OFS)   ? rd_ctrl :
                          (wb_adr_i == COUNT_OFS)  ? {16'h0000, count} :
                          (wb_adr_i == RELOAD_OFS) ? {16'h0000, reload} :
                          (wb_adr_i == PWM_OFS)    ? {16'h0000, pwm} :
                          (wb_adr_i == STATUS_OFS) ? rd_status :
                          32'h00000000;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req & ~wb_ack_o;
      if (bus_req && !wb_ack_o) begin
        wb_dat_o <= rd_word;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // Properties on a register leave out a bus write in the same cycle, since
  // software may legally override the count, the value or the control word.

  capture_copy_a: assert property (
    cap_evt |=> pwm == $past(count))
    else $error("Capture did not copy the count.");

  capture_flag_a: assert property (
    cap_evt |=> capture_event_flag && timer_event)
    else $error("Capture did not set flag and event.");

  reload_flag_a: assert property (
    reload_evt && mode == MODE_CAP && !cap_evt |=> !capture_event_flag)
    else $error("Reload in capture mode left the flag set.");

  gated_hold_a: assert property (
    enable && mode == MODE_GATE && !in_active && !wr_count |=> $stable(count))
    else $error("Gated timer counted while input inactive.");

  gated_irq_a: assert property (
    gate_off |=> timer_event)
    else $error("Gate deassertion raised no event.");

  gated_restart_a: assert property (
    reload_evt && !wr_count |=> count == START_CNT)
    else $error("Reload did not restart the count at one.");

  gated_toggle_a: assert property (
    reload_evt && mode == MODE_GATE && !wr_ctrl |=> timer_out != $past(timer_out))
    else $error("Gated reload did not toggle the output.");

  disabled_hold_a: assert property (
    !enable && !wr_count |=> $stable(count))
    else $error("Disabled timer changed its count.");

  pwm_level_a: assert property (
    enable && mode == MODE_PWM && !wr_ctrl |=> timer_out == $past(pwm_high))
    else $error("PWM output does not follow count and value.");

  reload_event_a: assert property (
    reload_evt && mode == MODE_CAP |=> timer_event)
    else $error("Reload in capture mode raised no event.");

  pwm_pol_one_a: assert property (
    enable && mode == MODE_PWM && input_polarity_select && !wr_ctrl
    |=> timer_out == ($past(count) <= $past(pwm)))
    else $error("PWM output wrong with polarity set.");

  pwm_pol_zero_a: assert property (
    enable && mode == MODE_PWM && !input_polarity_select && !wr_ctrl
    |=> timer_out == ($past(count) > $past(pwm)))
    else $error("PWM output wrong with polarity clear.");

  capture_edge_a: assert property (
    enable && mode == MODE_CAP &&
    (input_polarity_select ? $rose(timer_in) : $fell(timer_in))
    |=> capture_event_flag && timer_event)
    else $error("Selected input edge did not capture.");

  wrong_edge_a: assert property (
    enable && mode == MODE_CAP && !wr_pwm &&
    !(input_polarity_select ? $rose(timer_in) : $fell(timer_in)) |=> $stable(pwm))
    else $error("Capture without the selected input edge.");

  capture_only_a: assert property (
    !(enable && mode == MODE_CAP) && !wr_pwm |=> $stable(pwm))
    else $error("Capture register changed outside capture mode.");

  count_step_a: assert property (
    tick && !at_reload && !wr_count |=> count == 16'($past(count) + 16'h0001))
    else $error("Count did not advance by one on a tick.");

  gate_drop_a: assert property (
    enable && mode == MODE_GATE && $stable(input_polarity_select) &&
    $fell(timer_in == input_polarity_select) |=> timer_event)
    else $error("Gate input deassertion raised no event.");

  gate_wait_a: assert property (
    enable && mode == MODE_GATE && !in_active |=> pre_cnt == PRE_RST)
    else $error("Prescaler ran while the gate was closed.");

  flag_hold_a: assert property (
    !cap_evt && !(reload_evt && mode == MODE_CAP) |=> $stable(capture_event_flag))
    else $error("Capture flag changed without its event.");

  gated_out_hold_a: assert property (
    enable && mode == MODE_GATE && !reload_evt && !wr_ctrl |=> $stable(timer_out))
    else $error("Gated output changed without a reload.");

endmodule

//--- core/timer_pkg.sv
// Register map, field positions and constants of the 16-bit timer.
// Assumes a 32-bit classic Wishbone slave port with byte addressing.
package timer_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam int          ADR_W      = 5;
  localparam logic [4:0]  CTRL_OFS   = 5'h00;
  localparam logic [4:0]  COUNT_OFS  = 5'h04;
  localparam logic [4:0]  RELOAD_OFS = 5'h08;
  localparam logic [4:0]  PWM_OFS    = 5'h0c;
  localparam logic [4:0]  STATUS_OFS = 5'h10;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int          EN_BIT     = 0;
  localparam int          MODE_LSB   = 1;
  localparam int          POL_BIT    = 3;
  localparam int          PRE_LSB    = 4;
  localparam int          INIT_BIT   = 7;
  localparam int          OE_BIT     = 8;
  localparam int          CAP_BIT    = 9;
  localparam int          CTRL_W     = 9;
  localparam logic [8:0]  CTRL_RST   = 9'h000;

  // Timer modes held in the two-bit mode field.
  localparam logic [1:0]  MODE_PWM   = 2'h0;
  localparam logic [1:0]  MODE_CAP   = 2'h1;
  localparam logic [1:0]  MODE_CMP   = 2'h2;
  localparam logic [1:0]  MODE_GATE  = 2'h3;

  // ----------------------------------------------------------------
  // Status register fields and reset values
  // ----------------------------------------------------------------
  localparam int          ST_IN_BIT  = 0;
  localparam int          ST_OUT_BIT = 1;
  localparam int          ST_CAP_BIT = 2;
  localparam logic [15:0] COUNT_RST  = 16'h0000;
  localparam logic [15:0] RELOAD_RST = 16'hffff;
  localparam logic [15:0] PWM_RST    = 16'h0000;
  localparam logic [15:0] START_CNT  = 16'h0001;
  localparam logic [6:0]  PRE_RST    = 7'h00;

endpackage

//--- verif/pin_partner.sv
// Behavioural model of the pins beside the timer.
// Assumes the bench sets the wanted input level and its lag in cycles.
`timescale 1ns/100ps

module pin_partner (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // Bench control
  input  wire logic        level,
  input  wire logic [2:0]  lag,
  input  wire logic        clr,
  // Timer pins
  input  wire logic        timer_out,
  input  wire logic        timer_out_en,
  output logic             timer_in,
  output logic [15:0]      high_cnt
);
  logic [7:0] hist;

  // The input pin follows the wanted level lag plus one cycles later.
  assign timer_in = hist[lag];

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      hist     <= 8'h00;
      high_cnt <= 16'h0000;
    end else begin
      hist     <= {hist[6:0], level};
      high_cnt <= clr ? 16'h0000 : high_cnt + 16'(timer_out & timer_out_en);
    end
  end
endmodule

//--- verif/test_timer_core.sv
// Self-checking bench for the timer core and its pins.
// Assumes the design package and the pin model are compiled first.
`timescale 1ns/100ps

module test_timer_core
  import timer_pkg::*;
();
  logic             core_clk, nrst, cyc, stb, we, level, clr, pol;
  logic             wb_ack_o, timer_in, timer_out, timer_out_en, timer_event, ev_out;
  logic [ADR_W-1:0] adr;
  logic [3:0]       sel;
  logic [2:0]       lag;
  logic [15:0]      high_cnt;
  logic [31:0]      dat, wb_dat_o, rd, r1;
  int               errors, checks_done, seed, ev_cnt, cyc_n, ev_cyc, t0, i, p;

  timer_core timer_core_i (.core_clk(core_clk), .nrst(nrst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .timer_in(timer_in),
    .timer_out(timer_out), .timer_out_en(timer_out_en), .timer_event(timer_event));
  pin_partner pin_partner_i (.core_clk(core_clk), .nrst(nrst), .level(level), .lag(lag),
    .clr(clr), .timer_out(timer_out), .timer_out_en(timer_out_en),
    .timer_in(timer_in), .high_cnt(high_cnt));

  // ----------------------------------------------------------------
  // Clock, event monitor and helpers
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cyc_n <= cyc_n + 1;
    if (timer_event === 1'b1) begin
      ev_cnt <= ev_cnt + 1;
      ev_cyc <= cyc_n;
      ev_out <= timer_out;
    end
  end

  function automatic logic [31:0] ctl(input logic en, input logic [1:0] m,
                                      input logic pl, input logic [2:0] pre, input logic oe);
    return {23'h0, oe, 1'b1, pre, pl, m, en};
  endfunction

  function automatic int pwm_hi(input int rl, input int pw, input logic pl);
    return pl ? pw * 10 : (rl - pw) * 10;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hf;
    do begin
      @(posedge core_clk);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wait_ev(input int lim);
    int n, n0;
    n  = 0;
    n0 = ev_cnt;
    while (ev_cnt == n0 && n < lim) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= lim) chk(32'h0, 32'h1);
  endtask

  task automatic setup(input logic [1:0] m, input logic [2:0] pre, input int rl, input int pw);
    wb(1'b1, CTRL_OFS, ctl(1'b0, m, pol, pre, 1'b1));
    wb(1'b1, COUNT_OFS, 32'(START_CNT));
    wb(1'b1, RELOAD_OFS, 32'(rl));
    wb(1'b1, PWM_OFS, 32'(pw));
    wb(1'b1, CTRL_OFS, ctl(1'b1, m, pol, pre, 1'b1));
  endtask

  task automatic results;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    #300000;
    errors++;
    results;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {nrst, cyc, stb, we, level, clr, pol, adr, sel, dat, lag} = '0;
    {errors, checks_done, ev_cnt, cyc_n, ev_cyc} = '0;
    seed = 12279;
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    @(negedge core_clk);
    chk({30'h0, timer_out_en, timer_out}, 32'h0);
    wb(1'b1, 5'h14, 32'h1234);
    r1 = $random(seed);
    wb(1'b1, PWM_OFS, r1);
    wb(1'b0, PWM_OFS, 32'h0);
    chk(rd, {16'h0000, r1[15:0]});
    wb(1'b0, RELOAD_OFS, 32'h0);
    chk(rd, 32'(RELOAD_RST));
    wb(1'b0, 5'h14, 32'h0);
    chk(rd, 32'h0);
    $display("test registers done");
    for (i = 0; i < 4; i++) begin
      pol = i[0];
      p   = 1 + ($unsigned($random(seed)) % 9);
      setup(MODE_PWM, 3'h0, 10, p);
      repeat (40) @(posedge core_clk);
      clr <= 1'b1;
      @(posedge core_clk) clr <= 1'b0;
      repeat (100) @(posedge core_clk);
      #1 chk(32'(high_cnt), pwm_hi(10, p, pol));
    end
    $display("test pwm done");
    for (i = 0; i < 3; i++) begin
      p = 5 + ($unsigned($random(seed)) % 8);
      setup(MODE_CMP, 3'(i), p, 0);
      wait_ev(2000);
      t0 = ev_cyc;
      wait_ev(2000);
      chk(32'(ev_cyc - t0), 32'(p << i));
    end
    wb(1'b1, CTRL_OFS, ctl(1'b0, MODE_CMP, pol, 3'h0, 1'b1));
    wb(1'b0, COUNT_OFS, 32'h0);
    r1 = rd;
    repeat (20) @(posedge core_clk);
    wb(1'b0, COUNT_OFS, 32'h0);
    chk(rd, r1);
    $display("test compare done");
    for (i = 0; i < 2; i++) begin
      wb(1'b1, CTRL_OFS, 32'h0);
      pol   = i[0];
      lag   <= 3'($unsigned($random(seed)) % 4);
      level <= ~pol;
      setup(MODE_CAP, 3'h0, 300, 0);
      repeat (20) @(posedge core_clk);
      level <= pol;
      wait_ev(20);
      wb(1'b0, STATUS_OFS, 32'h0);
      chk(32'(rd[ST_CAP_BIT]), 32'h1);
      wb(1'b0, PWM_OFS, 32'h0);
      chk(32'(rd[15:0] != 16'h0), 32'h1);
      level <= ~pol;
      t0 = ev_cnt;
      repeat (20) @(posedge core_clk);
      chk(32'(ev_cnt), 32'(t0));
      wait_ev(400);
      wb(1'b0, CTRL_OFS, 32'h0);
      chk(32'(rd[CAP_BIT]), 32'h0);
    end
    $display("test capture done");
    pol   = 1'b1;
    lag   <= 3'h0;
    level <= 1'b0;
    setup(MODE_GATE, 3'h3, 4, 0);
    repeat (10) @(negedge core_clk);
    chk(32'(timer_out), 32'h1);
    chk(32'(timer_out_en), 32'h1);
    wb(1'b0, COUNT_OFS, 32'h0);
    chk(rd, 32'(START_CNT));
    level <= 1'b1;
    wait_ev(200);
    chk(32'(ev_out), 32'h0);
    @(posedge core_clk) level <= 1'b0;
    wait_ev(20);
    wb(1'b0, STATUS_OFS, 32'h0);
    chk(32'(rd[ST_IN_BIT] == pol), 32'h0);
    repeat (10) @(posedge core_clk);
    wb(1'b0, COUNT_OFS, 32'h0);
    chk(rd, 32'(START_CNT));
    $display("test gated done");
    results;
  end
endmodule
